// ### dv/flush_engine_model.sv
`timescale 1ns/1ps
`default_nettype none

module flush_engine_model (
    // Clock and reset
    input  wire logic MCLK,
    input  wire logic RST,
    // Flush handshake
    input  wire logic slow,
    input  wire logic flush_req,
    output var  logic flush_done
);
    int cnt;

    // ==========================================
    // Evicts 2 or 9 cycles after request, one-cycle done
    always @(posedge MCLK or posedge RST)
    begin
        flush_done <= 1'h0;
        cnt <= 0;
        if (!RST && flush_req && !flush_done)
        begin
            cnt <= cnt + 1;
            if (cnt == (slow ? 8 : 1))
                flush_done <= 1'h1;
        end
    end
endmodule

`default_nettype wire

// ### dv/sched_checker.sv
`timescale 1ns/1ps
`default_nettype none

module sched_checker (
    // Clock and reset
    input wire logic                  MCLK,
    input wire logic                  RST,
    // Register and flush
    input wire logic                  REG_RD,
    input wire logic                  REG_RVALID,
    input wire logic                  ASYNC_FLUSH_DONE,
    input wire logic                  ASYNC_ADVANCE_FLAG,
    input wire logic                  ASYNC_ADV_IRQ_ENABLE,
    input wire logic                  IRQ,
    // Walks
    input wire ehci_sched_pkg::word_t ASYNC_LIST_POINTER,
    input wire ehci_sched_pkg::word_t PERIODIC_LIST_POINTER,
    input wire logic                  ASYNC_WALK_EN,
    input wire ehci_sched_pkg::word_t ASYNC_WALK_ADDR,
    input wire logic                  PERIODIC_WALK_EN,
    input wire ehci_sched_pkg::word_t PERIODIC_WALK_ADDR
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // ==========================================
    // Properties
    read_answer_a: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    answer_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("answer without read");
    flag_cause_a: assert property ($rose(ASYNC_ADVANCE_FLAG) |-> $past(ASYNC_FLUSH_DONE))
        else $error("flag set before flush");
    async_skip_a: assert property (!ASYNC_WALK_EN |-> ASYNC_WALK_ADDR == 32'h0)
        else $error("async walked while off");
    async_addr_a: assert property (ASYNC_WALK_EN |-> ASYNC_WALK_ADDR == $past(ASYNC_LIST_POINTER))
        else $error("async walk address");
    per_skip_a: assert property (!PERIODIC_WALK_EN |-> PERIODIC_WALK_ADDR == 32'h0)
        else $error("periodic walked while off");
    per_addr_a: assert property (PERIODIC_WALK_EN |-> PERIODIC_WALK_ADDR == $past(PERIODIC_LIST_POINTER))
        else $error("periodic walk address");
    irq_cause_a: assert property (IRQ |-> ASYNC_ADVANCE_FLAG && $past(ASYNC_ADV_IRQ_ENABLE))
        else $error("irq without flag");
endmodule

bind ehci_schedule_enable_doorbell sched_checker u_sched_checker (.MCLK, .RST, .REG_RD,
    .REG_RVALID, .ASYNC_FLUSH_DONE, .ASYNC_ADVANCE_FLAG, .ASYNC_ADV_IRQ_ENABLE, .IRQ,
    .ASYNC_LIST_POINTER, .PERIODIC_LIST_POINTER, .ASYNC_WALK_EN, .ASYNC_WALK_ADDR,
    .PERIODIC_WALK_EN, .PERIODIC_WALK_ADDR);

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                  MCLK = 1'h0;
    logic                  RST = 1'h1;
    logic                  REG_WR = 1'h0;
    logic                  REG_RD = 1'h0;
    logic [7:0]            REG_ADDR = 8'h00;
    ehci_sched_pkg::word_t REG_WDATA = 32'h0;
    logic                  ASYNC_ADV_FLAG_CLR = 1'h0;
    logic                  ASYNC_ADV_IRQ_ENABLE = 1'h0;
    ehci_sched_pkg::word_t ASYNC_LIST_POINTER = 32'h1234_5000;
    ehci_sched_pkg::word_t PERIODIC_LIST_POINTER = 32'hABCD_E000;
    logic                  slow = 1'h0;
    logic                  ASYNC_FLUSH_DONE, ASYNC_FLUSH_REQ, REG_RVALID, ASYNC_ADVANCE_FLAG, IRQ;
    logic                  ASYNC_WALK_EN, PERIODIC_WALK_EN;
    ehci_sched_pkg::word_t REG_RDATA, ASYNC_WALK_ADDR, PERIODIC_WALK_ADDR;
    int                    bad_count = 0;
    int                    samples_checked = 0;

    always #10 MCLK = ~MCLK;

    ehci_schedule_enable_doorbell #(.MFRAME_CYCLES(4)) u_ehci_schedule_enable_doorbell (.MCLK,
        .RST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_RVALID,
        .ASYNC_ADV_FLAG_CLR, .ASYNC_ADV_IRQ_ENABLE, .ASYNC_ADVANCE_FLAG, .IRQ,
        .ASYNC_LIST_POINTER, .PERIODIC_LIST_POINTER, .ASYNC_FLUSH_DONE, .ASYNC_FLUSH_REQ,
        .ASYNC_WALK_EN, .ASYNC_WALK_ADDR, .PERIODIC_WALK_EN, .PERIODIC_WALK_ADDR);

    flush_engine_model u_flush_engine_model (.MCLK, .RST, .slow,
        .flush_req(ASYNC_FLUSH_REQ), .flush_done(ASYNC_FLUSH_DONE));

    // ==========================================
    // Helpers
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok)
        begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input ehci_sched_pkg::word_t d);
        @(posedge MCLK);
        #1;
        REG_WR = 1'h1;
        REG_ADDR = a;
        REG_WDATA = d;
        @(posedge MCLK);
        #1;
        REG_WR = 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input ehci_sched_pkg::word_t e);
        @(posedge MCLK);
        #1;
        REG_RD = 1'h1;
        REG_ADDR = a;
        @(posedge MCLK);
        #1;
        REG_RD = 1'h0;
        chk(REG_RVALID === 1'h1 && REG_RDATA === e, "read value");
    endtask

    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'h1; i++)
        begin
            @(posedge MCLK);
            #1;
        end
        if (s !== 1'h1)
        begin
            chk(1'b0, "timeout");
            end_of_test();
        end
    endtask

    // ==========================================
    // Scenarios
    task automatic t_regs();
        chk(IRQ === 1'h0 && ASYNC_ADVANCE_FLAG === 1'h0 && ASYNC_FLUSH_REQ === 1'h0, "reset out");
        chk(ASYNC_WALK_EN === 1'h0 && PERIODIC_WALK_EN === 1'h0, "reset walk");
        rd(8'h20, 32'h0008_0000);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, 32'h0);
        rd(8'h20, 32'h0008_0000);
        wr(8'h20, 32'h0008_0040);
        rd(8'h20, 32'h0008_0000);
        $display("t_regs done");
    endtask

    task automatic t_walk();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h20, 32'h0008_0000 | (i << 4));
            @(posedge MCLK);
            #1;
            chk(PERIODIC_WALK_EN === i[0], "periodic enable");
            chk(PERIODIC_WALK_ADDR === (i[0] ? PERIODIC_LIST_POINTER : 32'h0), "periodic");
            chk(ASYNC_WALK_EN === i[1], "async enable");
            chk(ASYNC_WALK_ADDR === (i[1] ? ASYNC_LIST_POINTER : 32'h0), "async");
        end
        $display("t_walk done");
    endtask

    task automatic t_doorbell(input logic s, input logic en);
        slow = s;
        ASYNC_ADV_IRQ_ENABLE = en;
        wr(8'h20, 32'h0008_0060);
        @(posedge MCLK);
        #1;
        chk(ASYNC_FLUSH_REQ === 1'h1, "flush request");
        wait_hi(ASYNC_ADVANCE_FLAG, 30);
        chk(ASYNC_FLUSH_REQ === 1'h0, "flush request drop");
        rd(8'h20, 32'h0008_0020);
        if (en)
            wait_hi(IRQ, 80);
        repeat (40) @(posedge MCLK);
        #1;
        chk(IRQ === en, "irq level");
        ASYNC_ADV_FLAG_CLR = 1'h1;
        @(posedge MCLK);
        #1;
        ASYNC_ADV_FLAG_CLR = 1'h0;
        chk(ASYNC_ADVANCE_FLAG === 1'h0 && IRQ === 1'h0, "flag clear");
        wr(8'h20, 32'h0008_0000);
        $display("t_doorbell done");
    endtask

    task automatic t_reset();
        wr(8'h20, 32'h0008_0030);
        @(posedge MCLK);
        #1;
        chk(ASYNC_WALK_EN === 1'h1 && PERIODIC_WALK_EN === 1'h1, "walk before reset");
        RST = 1'h1;
        repeat (2) @(posedge MCLK);
        #1;
        RST = 1'h0;
        chk(ASYNC_WALK_EN === 1'h0 && PERIODIC_WALK_EN === 1'h0, "walk after reset");
        rd(8'h20, 32'h0008_0000);
        $display("t_reset done");
    endtask

    initial
    begin
        repeat (12) @(posedge MCLK);
        #1;
        RST = 1'h0;
        t_regs();
        t_walk();
        t_doorbell(1'h0, 1'h1);
        t_doorbell(1'h1, 1'h0);
        t_reset();
        end_of_test();
    end
endmodule

`default_nettype wire

// ### pkg/ehci_sched_consts.svh
`ifndef EHCI_SCHED_CONSTS_SVH
`define EHCI_SCHED_CONSTS_SVH

// ==========================================
// Register map
`define HOST_COMMAND_OFFSET  8'h20
`define HOST_COMMAND_RESET   32'h0008_0000

// ==========================================
// Field positions
`define CMD_DOORBELL_BIT     6
`define CMD_ASYNC_EN_BIT     5
`define CMD_PERIODIC_EN_BIT  4
`define CMD_ITC_LSB          16
`define CMD_ITC_MSB          23
`define ITC_RESET            8'h08

// ==========================================
// Timing
`define MCLK_PERIOD_NS       20
`define MFRAME_NS            125000
`define MFRAME_CYCLES        (`MFRAME_NS / `MCLK_PERIOD_NS)

`endif

// ### pkg/ehci_sched_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ehci_sched_if;
    ehci_sched_pkg::itc_t irq_threshold_ctrl;
    logic                 boundary;

    modport ctrl  (output irq_threshold_ctrl, input boundary);
    modport timer (input irq_threshold_ctrl, output boundary);
endinterface

`default_nettype wire

// ### pkg/ehci_sched_pkg.sv
package ehci_sched_pkg;

    typedef logic [31:0] word_t;
    typedef logic [7:0]  itc_t;

    typedef enum logic [1:0]
    {
        DB_IDLE   = 2'h0,
        DB_FLUSH  = 2'h1,
        DB_RETIRE = 2'h3
    } doorbell_state_e;

endpackage

// ### verilog/ehci_schedule_enable_doorbell.sv
`timescale 1ns/1ps
`default_nettype none

`include "ehci_sched_consts.svh"

module ehci_schedule_enable_doorbell #(
    parameter int MFRAME_CYCLES = `MFRAME_CYCLES
) (
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    // Register port
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    input  wire logic [7:0]            REG_ADDR,
    input  wire ehci_sched_pkg::word_t REG_WDATA,
    output var  ehci_sched_pkg::word_t REG_RDATA,
    output var  logic                  REG_RVALID,
    // Status and interrupt enable bits
    input  wire logic                  ASYNC_ADV_FLAG_CLR,
    input  wire logic                  ASYNC_ADV_IRQ_ENABLE,
    output var  logic                  ASYNC_ADVANCE_FLAG,
    output var  logic                  IRQ,
    // Schedule engines
    input  wire ehci_sched_pkg::word_t ASYNC_LIST_POINTER,
    input  wire ehci_sched_pkg::word_t PERIODIC_LIST_POINTER,
    input  wire logic                  ASYNC_FLUSH_DONE,
    output var  logic                  ASYNC_FLUSH_REQ,
    output var  logic                  ASYNC_WALK_EN,
    output var  ehci_sched_pkg::word_t ASYNC_WALK_ADDR,
    output var  logic                  PERIODIC_WALK_EN,
    output var  ehci_sched_pkg::word_t PERIODIC_WALK_ADDR
);

    ehci_sched_if th ();

    ehci_sched_pkg::word_t           cmd_r;
    ehci_sched_pkg::word_t           cmd_nxt;
    ehci_sched_pkg::doorbell_state_e state_r;
    ehci_sched_pkg::doorbell_state_e state_nxt;
    logic                            flag_r;
    logic                            flag_nxt;
    logic                            irq_r;
    logic                            irq_nxt;
    logic                            flush_req_r;
    logic                            flush_req_nxt;
    ehci_sched_pkg::word_t           rdata_r;
    ehci_sched_pkg::word_t           rdata_nxt;
    logic                            rvalid_r;
    logic                            rvalid_nxt;
    logic                            aw_en_r;
    logic                            aw_en_nxt;
    logic                            pw_en_r;
    logic                            pw_en_nxt;
    ehci_sched_pkg::word_t           aw_addr_r;
    ehci_sched_pkg::word_t           aw_addr_nxt;
    ehci_sched_pkg::word_t           pw_addr_r;
    ehci_sched_pkg::word_t           pw_addr_nxt;
    logic                            cmd_hit;
    logic                            ring;

    // ==========================================
    // Threshold timer
    assign th.irq_threshold_ctrl = cmd_r[`CMD_ITC_MSB:`CMD_ITC_LSB];

    irq_threshold_timer #(
        .MFRAME_CYCLES (MFRAME_CYCLES)
    ) u_timer (
        .clk (MCLK),
        .rst (RST),
        .th  (th)
    );

    // ==========================================
    // Command register
    always_comb
    begin
        cmd_hit = (REG_ADDR == `HOST_COMMAND_OFFSET);
        cmd_nxt = cmd_r;
        ring    = 1'b0;
        if (REG_WR && cmd_hit)
        begin
            cmd_nxt = REG_WDATA;
            // Ring only with async schedule on; zero writes keep a pending ring
            ring    = REG_WDATA[`CMD_DOORBELL_BIT] & REG_WDATA[`CMD_ASYNC_EN_BIT];
            cmd_nxt[`CMD_DOORBELL_BIT] = cmd_r[`CMD_DOORBELL_BIT] | ring;
        end
        if (state_r == ehci_sched_pkg::DB_RETIRE && !ring)
        begin
            cmd_nxt[`CMD_DOORBELL_BIT] = 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            cmd_r <= `HOST_COMMAND_RESET;
        end
        else
        begin
            cmd_r <= cmd_nxt;
        end
    end

    // ==========================================
    // Doorbell handshake and status flag
    always_comb
    begin
        state_nxt = state_r;
        flag_nxt  = flag_r;
        if (ASYNC_ADV_FLAG_CLR)
        begin
            flag_nxt = 1'b0;
        end
        case (state_r)
            ehci_sched_pkg::DB_IDLE:
            begin
                if (cmd_r[`CMD_DOORBELL_BIT])
                begin
                    state_nxt = ehci_sched_pkg::DB_FLUSH;
                end
            end
            ehci_sched_pkg::DB_FLUSH:
            begin
                if (ASYNC_FLUSH_DONE)
                begin
                    flag_nxt  = 1'b1;
                    state_nxt = ehci_sched_pkg::DB_RETIRE;
                end
            end
            ehci_sched_pkg::DB_RETIRE:
            begin
                state_nxt = ehci_sched_pkg::DB_IDLE;
            end
            default:
            begin
                state_nxt = ehci_sched_pkg::DB_IDLE;
            end
        endcase
        flush_req_nxt = (state_nxt == ehci_sched_pkg::DB_FLUSH);
        // Interrupt waits for a threshold boundary, then holds while flag and enable stay
        irq_nxt = flag_nxt & ASYNC_ADV_IRQ_ENABLE & (irq_r | th.boundary);
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_r     <= ehci_sched_pkg::DB_IDLE;
            flag_r      <= 1'b0;
            irq_r       <= 1'b0;
            flush_req_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            flag_r      <= flag_nxt;
            irq_r       <= irq_nxt;
            flush_req_r <= flush_req_nxt;
        end
    end

    // ==========================================
    // Schedule walk enables and pointers
    always_comb
    begin
        aw_en_nxt   = cmd_r[`CMD_ASYNC_EN_BIT];
        pw_en_nxt   = cmd_r[`CMD_PERIODIC_EN_BIT];
        aw_addr_nxt = aw_en_nxt ? ASYNC_LIST_POINTER : '0;
        pw_addr_nxt = pw_en_nxt ? PERIODIC_LIST_POINTER : '0;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            aw_en_r   <= 1'b0;
            pw_en_r   <= 1'b0;
            aw_addr_r <= '0;
            pw_addr_r <= '0;
        end
        else
        begin
            aw_en_r   <= aw_en_nxt;
            pw_en_r   <= pw_en_nxt;
            aw_addr_r <= aw_addr_nxt;
            pw_addr_r <= pw_addr_nxt;
        end
    end

    // ==========================================
    // Register read path
    always_comb
    begin
        rvalid_nxt = REG_RD;
        rdata_nxt  = '0;
        if (REG_RD && cmd_hit)
        begin
            rdata_nxt = cmd_r;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign REG_RDATA          = rdata_r;
    assign REG_RVALID         = rvalid_r;
    assign ASYNC_ADVANCE_FLAG = flag_r;
    assign IRQ                = irq_r;
    assign ASYNC_FLUSH_REQ    = flush_req_r;
    assign ASYNC_WALK_EN      = aw_en_r;
    assign ASYNC_WALK_ADDR    = aw_addr_r;
    assign PERIODIC_WALK_EN   = pw_en_r;
    assign PERIODIC_WALK_ADDR = pw_addr_r;

endmodule

`default_nettype wire

// ### verilog/irq_threshold_timer.sv
`timescale 1ns/1ps
`default_nettype none

`include "ehci_sched_consts.svh"

module irq_threshold_timer #(
    parameter int MFRAME_CYCLES = `MFRAME_CYCLES
) (
    // Clock and reset
    input wire logic    clk,
    input wire logic    rst,
    // Threshold exchange
    ehci_sched_if.timer th
);

    localparam int DW = $clog2(MFRAME_CYCLES);
    localparam logic [DW-1:0] DIV_LAST = DW'(MFRAME_CYCLES - 1);

    logic [DW-1:0] div_r;
    logic [DW-1:0] div_nxt;
    logic [7:0]    mf_r;
    logic [7:0]    mf_nxt;
    logic          bnd_r;
    logic          bnd_nxt;
    logic          tick;
    logic [7:0]    mf_last;

    // ==========================================
    // Microframe divider and threshold counter
    always_comb
    begin
        tick    = (div_r == DIV_LAST);
        div_nxt = tick ? '0 : div_r + 1'b1;
        mf_last = (th.irq_threshold_ctrl == 8'h00) ? 8'h00 : th.irq_threshold_ctrl - 8'h01;
        mf_nxt  = mf_r;
        bnd_nxt = 1'b0;
        if (tick)
        begin
            if (mf_r >= mf_last)
            begin
                mf_nxt  = 8'h00;
                bnd_nxt = 1'b1;
            end
            else
            begin
                mf_nxt = mf_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            div_r <= '0;
            mf_r  <= 8'h00;
            bnd_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            mf_r  <= mf_nxt;
            bnd_r <= bnd_nxt;
        end
    end

    assign th.boundary = bnd_r;

endmodule

`default_nettype wire
